//--- hw/tmw_timer.v
// 16-bit timer with watch oscillator control, apb register slave
`timescale 1ns/1ps
// Functional notes
// RL1 - watch oscillator runs only while slow_osc_enable (control bit 3) is set
// RL2 - once enabled the oscillator keeps running in every power mode
// RL3 - system_clock_select 01 enters secondary run, everything on slow clock
// RL4 - sleep with idle_on_sleep clear and slow clock selected enters secondary idle
// RL5 - slow_clock_active_flag (bit 6) set exactly while slow clock is system clock
// RL6 - with monitor on, failed oscillator shows in flag as other source
// RL7 - low_power_osc_option set selects low-power level, default high power
// RL8 - count pair increments 0000h to FFFFh then wraps to 0000h
// RL9 - every wrap sets overflow_flag (bit 0) until software clears it
// RL10 - overflow interrupt raised only while overflow_irq_enable is set
// RL11 - compare mode 1011 special event trigger clears count pair to zero
// RL12 - software uses timer or synchronous mode when relying on special reset
// RL13 - with special reset, compare_value_pair sets the counter period
// RL14 - software count write in same cycle as trigger wins over clear
// RL15 - special event clear never sets overflow_flag
// RL16 - software waits for oscillator start-up before depending on it
// RL17 - for 1 s ticks software sets top bit of count_high_byte each overflow
// RL18 - real-time usage never writes count_low_byte
// RL19 - real-time usage: async mode, irq enable set, oscillator always on
// RL20 - source clear counts instruction cycles, set counts external rising edges
// RL21 - counter counts only while counter_on (bit 0) is set
// RL22 - wide_access_enable maps high byte to buffer, loaded on low read/write
// RL23 - synchronous mode synchronises external edges before counting
`include "tmw_consts.vh"

module tmw_timer (
    input  wire        pclk,          // system clock
    input  wire        presetn,       // async reset, active low
    input  wire        psel,          // apb select
    input  wire        penable,       // apb access phase
    input  wire        pwrite,        // apb direction
    input  wire [7:0]  paddr,         // apb byte address
    input  wire [31:0] pwdata,        // apb write data
    output reg  [31:0] prdata,        // apb read data
    output reg         pready,        // apb ready
    output reg         pslverr,       // apb error, unmapped address
    input  wire        ext_clk_in,    // external count input
    input  wire        osc_in_pin,    // watch oscillator output, sampled
    input  wire        sleep_req,     // sleep instruction executed, pulse
    input  wire        wake_req,      // wake event, pulse
    input  wire        clk_mon_en,    // clock monitor enabled
    input  wire        osc_fail,      // monitor saw watch oscillator fail
    output reg         osc_run_q,     // watch oscillator amplifier enable
    output reg         osc_lowpwr_q,  // oscillator low-power level
    output reg  [1:0]  pwr_mode_q,    // current power mode
    output reg         sys_slow_q,    // system clocked from watch oscillator
    output reg         irq_q,         // overflow interrupt request
    output reg         special_evt_q  // special event pulse, also for converter
);

    // =====================================================
    // registers
    reg [7:0]  ctrl_q;
    reg [7:0]  osc_ctrl_q;
    reg [15:0] cnt_q;
    reg [7:0]  hi_buf_q;
    reg        ovf_flag_q;
    reg        ovf_en_q;
    reg [3:0]  cmp_mode_q;
    reg [15:0] cmp_val_q;
    reg        lposc_q;
    reg [1:0]  div_q;
    reg        instr_en_q;
    reg [2:0]  ps_q;
    reg        src_s1_q;
    reg        src_s2_q;
    reg        src_prev_q;
    reg        run_flag_q;

    wire       acc_ok  = psel & penable & pready;
    wire       wr_acc  = acc_ok & pwrite & ~pslverr;
    wire       rd_acc  = acc_ok & ~pwrite & ~pslverr;
    wire       wr_lo   = wr_acc & (paddr == `TMW_OFF_CNT_LO);
    wire       wr_hi   = wr_acc & (paddr == `TMW_OFF_CNT_HI);
    wire       rd_lo   = rd_acc & (paddr == `TMW_OFF_CNT_LO);
    wire       wide    = ctrl_q[`TMW_CTRL_WIDE];
    wire       nosync  = ctrl_q[`TMW_CTRL_NOSYNC];
    wire       ext_sel = ctrl_q[`TMW_CTRL_SRC];
    wire [1:0] ps_sel  = ctrl_q[`TMW_CTRL_PS_HI:`TMW_CTRL_PS_LO];
    // a wide-mode high write only fills the buffer, so it must not stall the count
    wire       cnt_wr  = wr_lo | (wr_hi & ~wide);

    // =====================================================
    // address decode
    reg mapped;
    always @* begin
        case (paddr)
            `TMW_OFF_CTRL, `TMW_OFF_CNT_LO, `TMW_OFF_CNT_HI,
            `TMW_OFF_OSC_CTRL, `TMW_OFF_FLAG, `TMW_OFF_ENABLE,
            `TMW_OFF_CMP_MODE, `TMW_OFF_CMP_VAL, `TMW_OFF_CONFIG,
            `TMW_OFF_PWR_STAT: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    // read mux, sampled into prdata on the wait-state edge
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        case (paddr)
            `TMW_OFF_CTRL:     rd_val[7:0] = {ctrl_q[7], run_flag_q, ctrl_q[5:0]}; // RL5
            `TMW_OFF_CNT_LO:   rd_val[7:0] = cnt_q[7:0];
            `TMW_OFF_CNT_HI:   rd_val[7:0] = wide ? hi_buf_q : cnt_q[15:8]; // RL22
            `TMW_OFF_OSC_CTRL: rd_val[7:0] = osc_ctrl_q;
            `TMW_OFF_FLAG:     rd_val[0]   = ovf_flag_q;
            `TMW_OFF_ENABLE:   rd_val[0]   = ovf_en_q;
            `TMW_OFF_CMP_MODE: rd_val[3:0] = cmp_mode_q;
            `TMW_OFF_CMP_VAL:  rd_val[15:0] = cmp_val_q;
            `TMW_OFF_CONFIG:   rd_val[0]   = lposc_q;
            `TMW_OFF_PWR_STAT: rd_val[1:0] = pwr_mode_q;
            default:           rd_val = 32'h0000_0000;
        endcase
    end

    // =====================================================
    // apb handshake: one wait state, so prdata is a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= mapped ? rd_val : 32'h0000_0000;
            end
        end
    end

    // =====================================================
    // software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `TMW_CTRL_RST;
            osc_ctrl_q <= `TMW_OSC_CTRL_RST;
            ovf_en_q   <= 1'b0;
            cmp_mode_q <= 4'h0;
            cmp_val_q  <= `TMW_CMP_VAL_RST;
            lposc_q    <= 1'b0; // high power is default
        end else if (wr_acc) begin
            case (paddr)
                // flag bit 6 is status only, never stored
                `TMW_OFF_CTRL:     ctrl_q     <= {pwdata[7], 1'b0, pwdata[5:0]};
                `TMW_OFF_OSC_CTRL: osc_ctrl_q <= {pwdata[7], 5'h00, pwdata[1:0]};
                `TMW_OFF_ENABLE:   ovf_en_q   <= pwdata[`TMW_EN_OVF]; // RL10
                `TMW_OFF_CMP_MODE: cmp_mode_q <= pwdata[3:0];
                `TMW_OFF_CMP_VAL:  cmp_val_q  <= pwdata[15:0];
                `TMW_OFF_CONFIG:   lposc_q    <= pwdata[`TMW_CFG_LPOSC];
                default:           ctrl_q     <= ctrl_q;
            endcase
        end
    end

    // =====================================================
    // oscillator drive follows its enable alone, power modes never touch it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_run_q    <= 1'b0;
            osc_lowpwr_q <= 1'b0;
        end else begin
            osc_run_q    <= ctrl_q[`TMW_CTRL_OSC_EN]; // RL1 RL2
            osc_lowpwr_q <= lposc_q;                  // RL7
        end
    end

    // =====================================================
    // clock source: instruction enable and external edge detect
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q      <= 2'h0;
            instr_en_q <= 1'b0;
            src_s1_q   <= 1'b0;
            src_s2_q   <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            div_q      <= div_q + 2'h1;
            instr_en_q <= (div_q == `TMW_INSTR_DIV);
            src_s1_q   <= ctrl_q[`TMW_CTRL_OSC_EN] ? osc_in_pin : ext_clk_in;
            src_s2_q   <= src_s1_q;
            src_prev_q <= nosync ? src_s1_q : src_s2_q;
        end
    end

    // async mode skips the second stage, trading phase for latency
    wire src_now  = nosync ? src_s1_q : src_s2_q; // RL23
    wire ext_rise = src_now & ~src_prev_q;
    wire raw_tick = ctrl_q[`TMW_CTRL_ON] &
                    (ext_sel ? ext_rise : instr_en_q); // RL20 RL21

    // prescaler 1, 2, 4 or 8
    reg ps_hit;
    always @* begin
        case (ps_sel)
            2'h0:    ps_hit = 1'b1;
            2'h1:    ps_hit = ps_q[0];
            2'h2:    ps_hit = &ps_q[1:0];
            default: ps_hit = &ps_q;
        endcase
    end
    wire tick = raw_tick & ps_hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_q <= 3'h0;
        end else if (wr_lo) begin
            ps_q <= 3'h0;
        end else if (raw_tick) begin
            ps_q <= ps_hit ? 3'h0 : ps_q + 3'h1;
        end
    end

    // =====================================================
    // special event: compare match in mode 1011, not in async counting
    wire special_mode = (cmp_mode_q == `TMW_CMP_SPECIAL);
    wire special_ok   = ~(ext_sel & nosync);
    wire special_hit  = special_mode & special_ok & (cnt_q == cmp_val_q)
                        & ctrl_q[`TMW_CTRL_ON]; // RL11 RL13

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_evt_q <= 1'b0;
        end else begin
            special_evt_q <= special_hit & ~cnt_wr; // RL14
        end
    end

    // =====================================================
    // count pair: write beats special clear beats increment
    wire wrap = tick & (cnt_q == `TMW_CNT_MAX);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= `TMW_CNT_RST;
            hi_buf_q <= 8'h00;
        end else begin
            if (rd_lo & wide) begin
                hi_buf_q <= cnt_q[15:8]; // RL22
            end
            if (wr_hi) begin
                if (wide) begin
                    hi_buf_q <= pwdata[7:0]; // RL22
                end else begin
                    cnt_q[15:8] <= pwdata[7:0];
                end
            end
            if (wr_lo) begin
                cnt_q[7:0] <= pwdata[7:0];
                if (wide) begin
                    cnt_q[15:8] <= hi_buf_q; // RL22
                end
            end else if (wr_hi & ~wide) begin
                cnt_q[7:0] <= cnt_q[7:0]; // RL14
            end else if (special_hit) begin
                cnt_q <= `TMW_CNT_RST; // RL11
            end else if (tick) begin
                cnt_q <= cnt_q + 16'h0001; // RL8
            end
        end
    end

    // =====================================================
    // overflow flag: set wins over a same-cycle software clear
    wire ovf_set = wrap & ~cnt_wr & ~special_hit; // RL15
    wire ovf_clr = wr_acc & (paddr == `TMW_OFF_FLAG) & ~pwdata[`TMW_FLAG_OVF];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            if (ovf_set) begin
                ovf_flag_q <= 1'b1; // RL9
            end else if (ovf_clr) begin
                ovf_flag_q <= 1'b0;
            end
            irq_q <= (ovf_flag_q | ovf_set) & ovf_en_q; // RL10
        end
    end

    // =====================================================
    // power mode machine
    wire [1:0] clk_sel   = osc_ctrl_q[`TMW_OSC_SEL_HI:`TMW_OSC_SEL_LO];
    wire       slow_sel  = (clk_sel == `TMW_SEL_SLOW);
    wire       idle_bit  = osc_ctrl_q[`TMW_OSC_IDLE];
    wire [1:0] awake_pm  = slow_sel ? `TMW_PM_SEC_RUN : `TMW_PM_RUN;
    reg  [1:0] pm_d;
    always @* begin
        pm_d = pwr_mode_q;
        case (pwr_mode_q)
            `TMW_PM_RUN, `TMW_PM_SEC_RUN: begin
                if (sleep_req & slow_sel & ~idle_bit) begin
                    pm_d = `TMW_PM_SEC_IDLE; // RL4
                end else if (sleep_req) begin
                    pm_d = `TMW_PM_SLEEP;
                end else begin
                    pm_d = awake_pm; // RL3
                end
            end
            `TMW_PM_SEC_IDLE, `TMW_PM_SLEEP: begin
                if (wake_req) begin
                    pm_d = awake_pm;
                end
            end
            default: pm_d = `TMW_PM_RUN;
        endcase
    end

    // slow clock flag drops if the monitor swapped to a backup source
    wire slow_src = slow_sel & (pwr_mode_q != `TMW_PM_SLEEP)
                    & ~(clk_mon_en & osc_fail); // RL5 RL6
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_mode_q <= `TMW_PM_RUN;
            run_flag_q <= 1'b0;
            sys_slow_q <= 1'b0;
        end else begin
            pwr_mode_q <= pm_d;
            run_flag_q <= slow_src; // RL5
            sys_slow_q <= slow_src;
        end
    end

endmodule // tmw_timer

//--- hw/tmw_consts.vh
// constants of the timer with watch oscillator
`ifndef TMW_CONSTS_VH
`define TMW_CONSTS_VH
// =====================================================
// register byte offsets
`define TMW_OFF_CTRL      8'h00
`define TMW_OFF_CNT_LO    8'h04
`define TMW_OFF_CNT_HI    8'h08
`define TMW_OFF_OSC_CTRL  8'h0C
`define TMW_OFF_FLAG      8'h10
`define TMW_OFF_ENABLE    8'h14
`define TMW_OFF_CMP_MODE  8'h18
`define TMW_OFF_CMP_VAL   8'h1C
`define TMW_OFF_CONFIG    8'h20
`define TMW_OFF_PWR_STAT  8'h24
// =====================================================
// timer control fields
`define TMW_CTRL_ON       0
`define TMW_CTRL_SRC      1
`define TMW_CTRL_NOSYNC   2
`define TMW_CTRL_OSC_EN   3
`define TMW_CTRL_PS_LO    4
`define TMW_CTRL_PS_HI    5
`define TMW_CTRL_RUNFLG   6
`define TMW_CTRL_WIDE     7
// oscillator control, flag, enable and config fields
`define TMW_OSC_SEL_LO    0
`define TMW_OSC_SEL_HI    1
`define TMW_OSC_IDLE      7
`define TMW_FLAG_OVF      0
`define TMW_EN_OVF        0
`define TMW_CFG_LPOSC     0
// =====================================================
// codes and reset values
`define TMW_SEL_SLOW      2'h1
`define TMW_CMP_SPECIAL   4'hB
`define TMW_CNT_MAX       16'hFFFF
`define TMW_CNT_RST       16'h0000
`define TMW_CTRL_RST      8'h00
`define TMW_OSC_CTRL_RST  8'h00
`define TMW_CMP_VAL_RST   16'hFFFF
// instruction cycle is four system clocks
`define TMW_INSTR_DIV     2'h3
// power modes
`define TMW_PM_RUN        2'h0
`define TMW_PM_SEC_RUN    2'h1
`define TMW_PM_SEC_IDLE   2'h2
`define TMW_PM_SLEEP      2'h3
`endif

//--- verif/tmw_checker.sv
// concurrent checks on the ports of the timer with watch oscillator
`timescale 1ns/1ps
`include "tmw_consts.vh"
module tmw_checker (
    input wire        pclk,          // clock
    input wire        presetn,       // async reset, low
    input wire        psel,          // apb select
    input wire        penable,       // apb access
    input wire        pwrite,        // apb direction
    input wire [7:0]  paddr,         // apb address
    input wire [31:0] pwdata,        // apb write data
    input wire        pready,        // apb ready
    input wire        sleep_req,     // sleep pulse
    input wire        clk_mon_en,    // clock monitor on
    input wire        osc_run_q,     // oscillator enable
    input wire        osc_lowpwr_q,  // low-power level
    input wire [1:0]  pwr_mode_q,    // power mode
    input wire        sys_slow_q,    // slow clock flag
    input wire        irq_q,         // overflow request
    input wire        special_evt_q  // special event pulse
);
    // ==========================================
    // shadows of bits the ports cannot show
    wire       wr_done = psel && penable && pready && pwrite;
    reg  [1:0] sel_q;
    reg        idle_q;
    reg  [3:0] cmp_mode_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q      <= 2'h0;
            idle_q     <= 1'b0;
            cmp_mode_q <= 4'h0;
        end else if (wr_done && paddr == `TMW_OFF_OSC_CTRL) begin
            sel_q  <= pwdata[1:0];
            idle_q <= pwdata[7];
        end else if (wr_done && paddr == `TMW_OFF_CMP_MODE) begin
            cmp_mode_q <= pwdata[3:0];
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr_ctrl;
        wr_done && paddr == `TMW_OFF_CTRL;
    endsequence
    sequence s_wr_osc;
        wr_done && paddr == `TMW_OFF_OSC_CTRL;
    endsequence
    osc_enable_a: assert property (s_wr_ctrl |-> ##2 osc_run_q == $past(pwdata[3], 2))
        else $error("oscillator enable does not follow control bit");
    osc_keep_a: assert property (pwr_mode_q != 2'h0 && !$past(psel) && !$past(psel, 2)
        |-> $stable(osc_run_q)) else $error("oscillator changed in power mode");
    sec_run_a: assert property (s_wr_osc ##0 pwr_mode_q == 2'h0 ##0 pwdata[1:0] == 2'h1
        |-> ##[1:3] pwr_mode_q == `TMW_PM_SEC_RUN) else $error("no secondary run");
    sleep_mode_a: assert property (sleep_req && pwr_mode_q < 2'h2 |-> ##[1:2]
        pwr_mode_q == ((sel_q == `TMW_SEL_SLOW && !idle_q) ? 2'h2 : 2'h3))
        else $error("wrong mode after sleep");
    slow_flag_a: assert property (s_wr_osc ##0 !clk_mon_en ##0 pwr_mode_q < 2'h2
        |-> ##3 sys_slow_q == ($past(pwdata[1:0], 3) == `TMW_SEL_SLOW))
        else $error("slow clock flag wrong");
    low_power_a: assert property (wr_done && paddr == `TMW_OFF_CONFIG
        |-> ##2 osc_lowpwr_q == $past(pwdata[0], 2)) else $error("low-power level wrong");
    irq_mask_a: assert property (wr_done && paddr == `TMW_OFF_ENABLE && !pwdata[0]
        |-> ##2 !irq_q [*2]) else $error("interrupt while disabled");
    evt_mode_a: assert property (special_evt_q |-> cmp_mode_q == `TMW_CMP_SPECIAL)
        else $error("special event outside mode 1011");
    evt_pulse_a: assert property (special_evt_q |=> !special_evt_q)
        else $error("special event longer than a cycle");
    evt_no_ovf_a: assert property (special_evt_q |=> !$rose(irq_q) ##1 !$rose(irq_q))
        else $error("special event raised overflow");
endmodule // tmw_checker
bind tmw_timer tmw_checker u_tmw_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .sleep_req, .clk_mon_en, .osc_run_q, .osc_lowpwr_q, .pwr_mode_q,
    .sys_slow_q, .irq_q, .special_evt_q);

//--- verif/tmw_crystal.sv
// watch crystal model, square wave while the amplifier is enabled
`timescale 1ns/1ps
module tmw_crystal #(
    parameter real HALF_NS = 51.3  // half period, unrelated to pclk
) (
    input  wire  run,     // amplifier enable from the timer
    output logic osc_out  // crystal square output
);
    // ==========================================
    // a stopped crystal sits low, it does not hold a toggling level
    initial osc_out = 1'b0;
    always #(HALF_NS) osc_out = run ? ~osc_out : 1'b0;
endmodule // tmw_crystal

//--- verif/timer_with_watch_oscillator_bench.sv
// self-checking bench of the timer with watch oscillator
`timescale 1ns/1ps
`include "tmw_consts.vh"
module timer_with_watch_oscillator_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        ext_clk_in, osc_in_pin, sleep_req, wake_req, clk_mon_en, osc_fail;
    logic        osc_run_q, osc_lowpwr_q, sys_slow_q, irq_q, special_evt_q;
    logic [1:0]  pwr_mode_q;
    int          bad_count, checks_done, cyc, evt_n, seed, lo, ex;
    tmw_timer u_tmw_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_clk_in, .osc_in_pin, .sleep_req, .wake_req,
        .clk_mon_en, .osc_fail, .osc_run_q, .osc_lowpwr_q, .pwr_mode_q, .sys_slow_q,
        .irq_q, .special_evt_q);
    tmw_crystal u_tmw_crystal (.run(osc_run_q), .osc_out(osc_in_pin));
    // ==========================================
    // clock, cycle ceiling and event count
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (special_evt_q === 1'b1) evt_n++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic pulse(input logic w);
        @(posedge pclk);
        sleep_req <= !w;
        wake_req  <= w;
        @(posedge pclk);
        sleep_req <= 1'b0;
        wake_req  <= 1'b0;
        tick(3);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        seed = 32'h2E4FFD45;
        {psel, penable, pwrite, sleep_req, wake_req, clk_mon_en, osc_fail} = 7'h00;
        ext_clk_in = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        presetn    = 1'b0;
        tick(6);
        presetn <= 1'b1;
        // reset values, read-only flag bit, unmapped place
        apb(0, `TMW_OFF_CMP_VAL, 0);
        chk(rd, 32'h0000FFFF, "compare reset");
        apb(1, `TMW_OFF_CTRL, 32'h40);
        apb(0, `TMW_OFF_CTRL, 0);
        chk(rd, 32'h0, "flag bit not writable");
        apb(0, 8'h30, 0);
        chk(rd, 32'h0, "unmapped reads zero");
        chk(err_q, 1, "unmapped refused");
        $display("test registers done");
        // wrap from a random preload in timer mode
        lo = $random(seed) & 8'h3F;
        apb(1, `TMW_OFF_CNT_HI, 32'hFF);
        apb(1, `TMW_OFF_CNT_LO, lo);
        apb(1, `TMW_OFF_ENABLE, 1);
        apb(1, `TMW_OFF_CTRL, 1);
        tick((256 - lo) * 4 + 16);
        apb(0, `TMW_OFF_FLAG, 0);
        chk(rd, 1, "overflow flag");
        chk(irq_q, 1, "irq raised");
        apb(0, `TMW_OFF_CNT_HI, 0);
        chk(rd, 0, "wrapped to zero");
        apb(1, `TMW_OFF_ENABLE, 0);
        tick(2);
        chk(irq_q, 0, "irq masked");
        apb(1, `TMW_OFF_CTRL, 0);
        apb(1, `TMW_OFF_CNT_LO, 32'h55);
        tick(50);
        apb(0, `TMW_OFF_CNT_LO, 0);
        chk(rd, 32'h55, "counter stopped");
        apb(1, `TMW_OFF_FLAG, 0);
        $display("test wrap done");
        // special event as a period counter
        apb(1, `TMW_OFF_CMP_VAL, 32'h20);
        apb(1, `TMW_OFF_CMP_MODE, `TMW_CMP_SPECIAL);
        // start below the compare value, else the first match waits for a full wrap
        apb(1, `TMW_OFF_CNT_LO, 0);
        apb(1, `TMW_OFF_ENABLE, 1);
        apb(1, `TMW_OFF_CTRL, 1);
        evt_n = 0;
        tick(2000);
        ex = 2000 / ((32'h20 + 1) * 4);
        chk(evt_n >= ex - 1 && evt_n <= ex + 2, 1, "event count");
        apb(0, `TMW_OFF_CNT_LO, 0);
        chk(rd <= 32'h20, 1, "count within period");
        apb(0, `TMW_OFF_FLAG, 0);
        chk(rd, 0, "no flag from event");
        chk(irq_q, 0, "no irq from event");
        apb(1, `TMW_OFF_CTRL, 0);
        apb(1, `TMW_OFF_CMP_MODE, 0);
        $display("test special event done");
        // wide access through the high byte buffer
        apb(1, `TMW_OFF_CTRL, 32'h80);
        apb(1, `TMW_OFF_CNT_HI, 32'h12);
        apb(1, `TMW_OFF_CNT_LO, 32'h34);
        apb(1, `TMW_OFF_CTRL, 0);
        apb(0, `TMW_OFF_CNT_HI, 0);
        chk(rd, 32'h12, "wide high");
        apb(0, `TMW_OFF_CNT_LO, 0);
        chk(rd, 32'h34, "wide low");
        $display("test wide done");
        // crystal counting, low-power option
        apb(1, `TMW_OFF_CONFIG, 1);
        tick(3);
        chk(osc_lowpwr_q, 1, "low power level");
        apb(1, `TMW_OFF_CNT_HI, 0);
        apb(1, `TMW_OFF_CNT_LO, 0);
        apb(1, `TMW_OFF_CTRL, 32'h0B);
        tick(3);
        chk(osc_run_q, 1, "oscillator on");
        tick(2000);
        apb(1, `TMW_OFF_CTRL, 32'h08);
        ex = 10000 / 103;
        chk(osc_run_q, 1, "oscillator kept");
        apb(0, `TMW_OFF_CNT_LO, 0);
        chk(rd >= ex - 3 && rd <= ex + 3, 1, "crystal edges");
        lo = rd;
        // real-time usage: async counting, top-bit preload, low byte never touched
        apb(1, `TMW_OFF_ENABLE, 1);
        apb(1, `TMW_OFF_CNT_HI, 32'h80);
        apb(1, `TMW_OFF_CTRL, 32'h0F);
        tick(500);
        apb(1, `TMW_OFF_CTRL, 32'h08);
        apb(0, `TMW_OFF_CNT_HI, 0);
        chk(rd, 32'h80, "preload kept");
        apb(0, `TMW_OFF_CNT_LO, 0);
        chk(rd >= lo + 21 && rd <= lo + 28, 1, "async crystal edges");
        chk(irq_q, 0, "no early overflow");
        $display("test crystal done");
        // power modes on the slow clock
        apb(1, `TMW_OFF_OSC_CTRL, 1);
        tick(3);
        chk({pwr_mode_q, sys_slow_q}, {2'h1, 1'b1}, "secondary run");
        apb(0, `TMW_OFF_CTRL, 0);
        chk(rd, 32'h48, "flag bit read");
        pulse(0);
        chk({pwr_mode_q, osc_run_q}, {2'h2, 1'b1}, "secondary idle");
        pulse(1);
        chk(pwr_mode_q, 1, "woken");
        clk_mon_en <= 1'b1;
        osc_fail   <= 1'b1;
        tick(3);
        chk(sys_slow_q, 0, "failed oscillator");
        osc_fail <= 1'b0;
        clk_mon_en <= 1'b0;
        apb(1, `TMW_OFF_OSC_CTRL, 32'h81);
        pulse(0);
        chk(pwr_mode_q, 3, "full sleep");
        pulse(1);
        apb(1, `TMW_OFF_OSC_CTRL, 0);
        tick(3);
        chk({pwr_mode_q, sys_slow_q}, {2'h0, 1'b0}, "back to run");
        $display("test power done");
        end_of_test();
    end
endmodule // timer_with_watch_oscillator_bench
